// [bench/sps_peer.sv]
// External serial slave model for master-mode frames.
// Assumes the bench drives its select; sck comes from the device.
`timescale 1ns/10ps
module sps_peer (
   input wire logic sck_i,
   input wire logic mosi_i,
   input wire logic cs_n_i,
   input wire logic [7:0] rsp_i,
   output logic miso_o,
   output logic [7:0] got_o
);
   // ==========================================
   // Shift state
   logic [2:0] idx = 3'h0;
   logic idle = 1'b0;
   // Changing pattern while deselected, so a stale bit never matches
   always #7 idle = ~idle;
   always @(posedge sck_i or posedge cs_n_i) begin
      if (cs_n_i) begin
         got_o <= 8'h00;
      end else begin
         got_o <= {got_o[6:0], mosi_i};
      end
   end
   always @(negedge sck_i or posedge cs_n_i) begin
      if (cs_n_i) begin
         idx <= 3'h0;
      end else begin
         idx <= idx + 3'h1;
      end
   end
   assign miso_o = cs_n_i ? idle : rsp_i[3'h7 - idx];
endmodule

// [bench/sps_top_tb.sv]
// Self-checking bench for the serial port status and control block.
// Assumes sps_peer as the far-side slave; slave mode not driven.
`timescale 1ns/10ps
module sps_top_tb;
   import sps_pkg::*;
   // ==========================================
   // Signals
   typedef struct packed {
      logic w;
      logic [7:0] a;
      sps_byte_t d;
      sps_byte_t e;
   } sps_row_s;
   localparam sps_row_s ROWS [11] = '{
      '{1'b0, 8'hf8, 8'h00, 8'h00}, '{1'b0, 8'h9a, 8'h00, 8'h07},
      '{1'b0, 8'h10, 8'h00, 8'h00}, '{1'b1, 8'h9a, 8'h3b, 8'h00},
      '{1'b0, 8'h9a, 8'h00, 8'h03}, '{1'b1, 8'hf8, 8'hfc, 8'h00},
      '{1'b0, 8'hf8, 8'h00, 8'h00}, '{1'b1, 8'h9a, 8'h07, 8'h00},
      '{1'b0, 8'h9a, 8'h00, 8'h07}, '{1'b1, 8'hf8, 8'h03, 8'h00},
      '{1'b0, 8'hf8, 8'h00, 8'h03}};
   logic clk_i = 1'b0;
   logic link_clk = 1'b0;
   logic resetn_i = 1'b0;
   logic [7:0] addr = 8'h00;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic sel_n = 1'b1;
   // Raised after reset so the model starts from a clean state
   logic peer_cs_n = 1'b0;
   sps_byte_t wdata = 8'h00;
   sps_byte_t peer_rsp = 8'h00;
   sps_byte_t rdata;
   sps_byte_t peer_got;
   sps_byte_t v;
   logic [15:0] pair;
   logic irq, sck, sck_oe, mosi, mosi_oe, miso;
   int err_count = 0;
   int n_tests = 0;
   always #12.5 clk_i = ~clk_i;
   // Odd offset keeps the link clock unrelated in phase
   initial #3 forever #7.5 link_clk = ~link_clk;
   sps_top u_sps_top (.clk_i(clk_i), .resetn_i(resetn_i),
      .link_clk_i(link_clk), .sfr_addr_i(addr), .sfr_wr_i(wr),
      .sfr_rd_i(rd), .sfr_wdata_i(wdata), .sfr_rdata_o(rdata),
      .irq_o(irq), .slave_select_input_n_i(sel_n), .sck_o(sck),
      .sck_oe_o(sck_oe), .mosi_i(1'b0), .mosi_o(mosi),
      .mosi_oe_o(mosi_oe), .miso_i(miso), .miso_o(), .miso_oe_o());
   sps_peer u_sps_peer (.sck_i(sck), .mosi_i(mosi), .cs_n_i(peer_cs_n),
      .rsp_i(peer_rsp), .miso_o(miso), .got_o(peer_got));
   // ==========================================
   // Tasks
   task automatic wrap_up();
      if (err_count == 0 && n_tests > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic check(input sps_byte_t got, exp, input string m);
      n_tests++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask
   task automatic wr_reg(input logic [7:0] a, input sps_byte_t d);
      @(posedge clk_i);
      #2 addr = a;
      wdata = d;
      wr = 1'b1;
      @(posedge clk_i);
      #2 wr = 1'b0;
   endtask
   task automatic rd_reg(input logic [7:0] a, output sps_byte_t d);
      @(posedge clk_i);
      #2 addr = a;
      rd = 1'b1;
      @(posedge clk_i);
      #2 rd = 1'b0;
      d = rdata;
   endtask
   // Master frame with a colliding second write
   task automatic xfer(input int c, input sps_byte_t tx, rsp,
         input logic ovr);
      int k;
      sps_byte_t s;
      wr_reg(8'h9a, 8'(c));
      peer_rsp = rsp;
      peer_cs_n = 1'b0;
      wr_reg(8'h9b, tx);
      wr_reg(8'h9b, ~tx);
      rd_reg(8'hf8, s);
      check(s & 8'h48, 8'h48, "busy or collision");
      check({6'h00, sck_oe, mosi_oe}, 8'h03, "drive enables");
      k = 0;
      while (s[7] !== 1'b1 && k < 300) begin
         rd_reg(8'hf8, s);
         k++;
      end
      if (k == 300) begin
         err_count++;
         $display("CHECK FAILED t=%0t no transfer end", $time);
         wrap_up();
      end
      check(s, {3'b110, ovr, 4'h3}, "end status");
      check({7'h00, irq}, 8'h01, "request");
      check(peer_got, tx >> (7 - c), "bits sent");
      peer_cs_n = 1'b1;
      wr_reg(8'hf8, 8'h13);
   endtask
   // ==========================================
   // Sequence
   initial begin
      repeat (6) @(posedge clk_i);
      #2 resetn_i = 1'b1;
      peer_cs_n = 1'b1;
      foreach (ROWS[i]) begin
         if (ROWS[i].w) begin
            wr_reg(ROWS[i].a, ROWS[i].d);
         end else begin
            rd_reg(ROWS[i].a, v);
            check(v, ROWS[i].e, "register row");
         end
      end
      // Every frame length code, received bits land low
      for (int c = 0; c < 8; c++) begin
         xfer(c, 8'h96 + 8'(c * 37), 8'h5a ^ 8'(c * 17), 1'b0);
         rd_reg(8'h9b, v);
         // Unsent transmit bits stay above the received ones
         pair = {8'h96 + 8'(c * 37), 8'h5a ^ 8'(c * 17)};
         check(v, 8'(pair >> (7 - c)), "rx byte");
      end
      // Third unread byte overflows the two-entry buffer
      xfer(7, 8'h11, 8'h11, 1'b0);
      xfer(7, 8'h22, 8'h22, 1'b0);
      xfer(7, 8'h33, 8'h33, 1'b1);
      rd_reg(8'hf8, v);
      check(v, 8'h13, "overrun held");
      check({7'h00, irq}, 8'h01, "overrun request");
      rd_reg(8'h9b, v);
      check(v, 8'h11, "old byte kept");
      rd_reg(8'h9b, v);
      check(v, 8'h22, "second byte kept");
      wr_reg(8'hf8, 8'h03);
      rd_reg(8'hf8, v);
      check(v, 8'h03, "overrun cleared");
      check({7'h00, irq}, 8'h00, "request dropped");
      // Another master pulls select low
      sel_n = 1'b0;
      repeat (6) @(posedge clk_i);
      rd_reg(8'hf8, v);
      check(v, 8'h24, "fault status");
      check({6'h00, sck_oe, mosi_oe}, 8'h00, "off line");
      check({7'h00, irq}, 8'h01, "fault request");
      sel_n = 1'b1;
      repeat (4) @(posedge clk_i);
      rd_reg(8'hf8, v);
      check(v, 8'h20, "fault held");
      wr_reg(8'hf8, 8'h00);
      rd_reg(8'hf8, v);
      check(v, 8'h00, "fault cleared");
      // Mid-run reset returns the registers to their reset values
      wr_reg(8'h9a, 8'h3b);
      wr_reg(8'hf8, 8'h03);
      @(posedge clk_i);
      #2 resetn_i = 1'b0;
      repeat (6) @(posedge clk_i);
      #2 resetn_i = 1'b1;
      rd_reg(8'hf8, v);
      check(v, 8'h00, "control after reset");
      rd_reg(8'h9a, v);
      check(v, 8'h07, "config after reset");
      check({7'h00, irq}, 8'h00, "request after reset");
      wrap_up();
   end
endmodule

// [hdl/sps_buf.sv]
// Small receive FIFO with valid/ready on both sides.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/10ps
module sps_buf #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 2
) (
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [CW-1:0] cnt;
   } sps_buf_s;
   sps_buf_s st, next_st;
   logic push, pop;
   function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
      return (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
   endfunction
   assign in_ready_o = (st.cnt != CW'(DEPTH));
   assign out_valid_o = (st.cnt != '0);
   assign out_data_o = st.mem[st.rp];
   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;
   always_comb begin
      next_st = st;
      if (push) begin
         next_st.mem[st.wp] = in_data_i;
         next_st.wp = bump(st.wp);
      end
      if (pop) begin
         next_st.rp = bump(st.rp);
      end
      if (push && !pop) begin
         next_st.cnt = st.cnt + 1'b1;
      end else if (pop && !push) begin
         next_st.cnt = st.cnt - 1'b1;
      end
   end
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end
endmodule

// [hdl/sps_link.sv]
// Shifter on the link clock: master frames and slave bytes.
// Assumes link_clk_i runs only during frames when a slave.
`timescale 1ns/10ps
`include "sps_map.svh"
module sps_link (
   input wire logic link_clk_i,
   input wire logic resetn_i,
   input wire logic miso_i,
   input wire logic mosi_i,
   output logic sck_o,
   output logic mosi_o,
   output logic miso_o,
   sps_link_if.link lk
);
   import sps_pkg::*;
   typedef struct packed {
      logic [1:0] rst_s;
      logic [2:0] start_s;
      logic [2:0] load_s;
      logic [1:0] mst_s;
      logic [1:0] slv_s;
      sps_lstate_e state;
      sps_byte_t sh;
      sps_byte_t rx_word;
      sps_cnt_t bit_index_count;
      sps_cnt_t nbits;
      logic ph;
      logic sck;
      logic mosi;
      logic miso;
      logic done_tgl;
   } sps_link_s;
   sps_link_s st, next_st;
   assign sck_o = st.sck;
   assign mosi_o = st.mosi;
   assign miso_o = st.miso;
   assign lk.done_tgl = st.done_tgl;
   assign lk.rx_word = st.rx_word;
   always_comb begin
      next_st = st;
      next_st.rst_s = {st.rst_s[0], resetn_i};
      next_st.start_s = {st.start_s[1:0], lk.start_tgl};
      next_st.load_s = {st.load_s[1:0], lk.load_tgl};
      next_st.mst_s = {st.mst_s[0], lk.master};
      next_st.slv_s = {st.slv_s[0], lk.slave_en};
      case (st.state)
         SPS_IDLE: begin
            if (st.mst_s[1]) begin
               if (tgl_edge(st.start_s)) begin
                  next_st.sh = lk.tx_word;
                  next_st.nbits = frame_bits(lk.flen);
                  next_st.bit_index_count = '0;
                  next_st.ph = 1'b0;
                  next_st.mosi = lk.tx_word[7];
                  next_st.state = SPS_SHIFT;
               end
            end else if (st.slv_s[1]) begin
               if (tgl_edge(st.load_s)) begin
                  next_st.sh = lk.tx_word;
                  next_st.miso = lk.tx_word[7];
               end else begin
                  next_st.sh = {st.sh[6:0], mosi_i};
                  next_st.miso = st.sh[6];
                  // Slave frames are always eight bits
                  if (st.bit_index_count == `SPS_SLAVE_BITS) begin
                     next_st.rx_word = {st.sh[6:0], mosi_i};
                     next_st.done_tgl = ~st.done_tgl;
                     next_st.bit_index_count = '0;
                  end else begin
                     next_st.bit_index_count = st.bit_index_count + 4'h1;
                  end
               end
            end else begin
               next_st.bit_index_count = '0;
            end
         end
         SPS_SHIFT: begin
            if (!st.ph) begin
               next_st.sck = 1'b1;
               next_st.sh = {st.sh[6:0], miso_i};
               next_st.bit_index_count = st.bit_index_count + 4'h1;
               next_st.ph = 1'b1;
            end else begin
               next_st.sck = 1'b0;
               next_st.mosi = st.sh[7];
               next_st.ph = 1'b0;
               if (st.bit_index_count == st.nbits) begin
                  next_st.state = SPS_END;
               end
            end
         end
         SPS_END: begin
            next_st.rx_word = st.sh;
            next_st.done_tgl = ~st.done_tgl;
            next_st.state = SPS_IDLE;
         end
         default: begin
            next_st.state = SPS_IDLE;
         end
      endcase
   end
   always_ff @(posedge link_clk_i) begin
      if (!st.rst_s[1]) begin
         st <= '0;
         st.rst_s <= next_st.rst_s;
         st.state <= SPS_IDLE;
      end else begin
         st <= next_st;
      end
   end
   frame_len_a: assert property (@(posedge link_clk_i)
      disable iff (!st.rst_s[1])
      st.state == SPS_END |-> st.bit_index_count == st.nbits
         && st.nbits >= 4'h1 && st.nbits <= 4'h8)
      else $error("master frame length wrong");
endmodule

// [hdl/sps_link_if.sv]
// Signals between the register side and the link-clock shifter.
// Toggles, enable levels and held words; each receiver synchronises the toggles and levels.
`timescale 1ns/10ps
interface sps_link_if;
   import sps_pkg::*;
   logic start_tgl;
   logic load_tgl;
   logic done_tgl;
   logic master;
   logic slave_en;
   sps_byte_t tx_word;
   sps_byte_t rx_word;
   sps_flen_t flen;
   modport core (output start_tgl, load_tgl, master, slave_en, tx_word,
      flen, input done_tgl, rx_word);
   modport link (input start_tgl, load_tgl, master, slave_en, tx_word,
      flen, output done_tgl, rx_word);
endinterface

// [hdl/sps_map.svh]
// Register offsets, bit positions and reset values of the serial port.
// Assumes an 8-bit special-function register space.
`ifndef SPS_MAP_SVH
`define SPS_MAP_SVH
`define SPS_CTRL_ADDR 8'hf8
`define SPS_CFG_ADDR 8'h9a
`define SPS_DATA_ADDR 8'h9b
`define SPS_CTRL_RESET 8'h00
`define SPS_CFG_RESET 8'h07
`define SPS_FLEN_RESET 3'h7
`define SPS_DONE_BIT 7
`define SPS_WRITE_COLLISION_FLAG_BIT 6
`define SPS_MODE_FAULT_FLAG_BIT 5
`define SPS_OVR_BIT 4
`define SPS_MST_BIT 1
`define SPS_EN_BIT 0
`define SPS_SLAVE_BITS 4'h7
`endif

// [hdl/sps_pkg.sv]
// Types and helper functions shared by the serial port modules.
// Assumes sps_map.svh is included by the modules that need offsets.
package sps_pkg;
   typedef logic [7:0] sps_byte_t;
   typedef logic [2:0] sps_flen_t;
   typedef logic [3:0] sps_cnt_t;
   typedef enum logic [2:0] {
      SPS_IDLE = 3'b001,
      SPS_SHIFT = 3'b010,
      SPS_END = 3'b100
   } sps_lstate_e;
   typedef struct packed {
      logic [1:0] nss_s;
      logic nss_prev;
      logic [2:0] done_s;
      logic transfer_done_flag;
      logic write_collision_flag;
      logic mode_fault_flag;
      logic receive_overrun_flag;
      logic transmit_busy_flag;
      logic slave_selected_flag;
      logic master_enable;
      logic interface_enable;
      logic [1:0] clk_cfg;
      sps_flen_t frame_length_select;
      sps_flen_t flen_tx;
      logic start_tgl;
      logic load_tgl;
      sps_byte_t tx_word;
      sps_byte_t rdata;
      logic irq;
      logic drive_oe;
      logic miso_oe;
   } sps_core_s;
   // Number of bits a master frame shifts, 1..8
   function automatic sps_cnt_t frame_bits(input sps_flen_t flen);
      return {1'b0, flen} + 4'h1;
   endfunction
   // Edge of a synchronised toggle
   function automatic logic tgl_edge(input logic [2:0] s);
      return s[1] ^ s[2];
   endfunction
endpackage

// [hdl/sps_top.sv]
// Serial port status, control and data registers with link shifter.
// Assumes an SFR bus on clk_i and a separate link clock.
//
// What this block does
// - The done flag sets at the end of a transfer and stays until cleared.
// - A set done flag raises the interrupt request.
// - A data write during a transfer sets the collision flag, held.
// - Master mode with slave select sampled low sets the fault flag.
// - Fault, collision and overrun flags also raise the request.
// - Fault and overrun flags clear only by a software zero write.
// - A byte arriving with the receive buffer full sets overrun.
// - Busy stays high during a master transfer and is read only.
// - Busy clears by itself when the master transfer completes.
// - A colliding data write is dropped; the transfer goes on.
// - On overrun the new byte is dropped and the old one kept.
// - A fault clears master enable and interface enable.
// - The selected flag reads one while slave select is low.
`timescale 1ns/10ps
`include "sps_map.svh"
module sps_top #(
   parameter int RX_DEPTH = 2
) (
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic link_clk_i,
   input wire logic [7:0] sfr_addr_i,
   input wire logic sfr_wr_i,
   input wire logic sfr_rd_i,
   input wire sps_pkg::sps_byte_t sfr_wdata_i,
   output sps_pkg::sps_byte_t sfr_rdata_o,
   output logic irq_o,
   input wire logic slave_select_input_n_i,
   output logic sck_o,
   output logic sck_oe_o,
   input wire logic mosi_i,
   output logic mosi_o,
   output logic mosi_oe_o,
   input wire logic miso_i,
   output logic miso_o,
   output logic miso_oe_o
);
   import sps_pkg::*;

   // ===========================================
   // Decode and events
   sps_core_s st, next_st;
   sps_link_if lk ();
   logic ctrl_wr, cfg_wr, data_wr, data_rd;
   logic done_evt, byte_evt, nss_rise, fault, in_prog;
   logic set_done, set_write_collision_flag, set_ovr;
   logic buf_ready, buf_valid;
   sps_byte_t buf_data;

   assign ctrl_wr = sfr_wr_i && (sfr_addr_i == `SPS_CTRL_ADDR);
   assign cfg_wr = sfr_wr_i && (sfr_addr_i == `SPS_CFG_ADDR);
   assign data_wr = sfr_wr_i && (sfr_addr_i == `SPS_DATA_ADDR);
   assign data_rd = sfr_rd_i && (sfr_addr_i == `SPS_DATA_ADDR);
   assign done_evt = tgl_edge(st.done_s);
   assign byte_evt = done_evt && st.interface_enable;
   assign nss_rise = st.nss_s[1] && !st.nss_prev;
   // Slave select low while mastering means a second master
   assign fault = st.interface_enable && st.master_enable
      && !st.nss_s[1];
   // A slave frame in progress counts as busy for collisions
   assign in_prog = st.transmit_busy_flag || (st.interface_enable
      && !st.master_enable && !st.nss_s[1]);
   assign set_done = (done_evt && st.transmit_busy_flag)
      || (nss_rise && st.interface_enable && !st.master_enable);
   assign set_write_collision_flag = data_wr && in_prog;
   assign set_ovr = byte_evt && !buf_ready;

   // ===========================================
   // Link side and receive buffer
   assign lk.start_tgl = st.start_tgl;
   assign lk.load_tgl = st.load_tgl;
   assign lk.tx_word = st.tx_word;
   assign lk.flen = st.flen_tx;
   assign lk.master = st.interface_enable && st.master_enable;
   assign lk.slave_en = st.interface_enable && !st.master_enable;

   sps_link u_link (
      .link_clk_i(link_clk_i),
      .resetn_i(resetn_i),
      .miso_i(miso_i),
      .mosi_i(mosi_i),
      .sck_o(sck_o),
      .mosi_o(mosi_o),
      .miso_o(miso_o),
      .lk(lk.link)
   );

   // Full buffer refuses the byte; the link cannot be stalled
   sps_buf #(
      .WIDTH(8),
      .DEPTH(RX_DEPTH)
   ) u_rxbuf (
      .clk_i(clk_i),
      .resetn_i(resetn_i),
      .in_valid_i(byte_evt),
      .in_ready_o(buf_ready),
      .in_data_i(lk.rx_word),
      .out_valid_o(buf_valid),
      .out_ready_i(data_rd),
      .out_data_o(buf_data)
   );

   // ===========================================
   // Next state
   always_comb begin
      next_st = st;
      next_st.nss_s = {st.nss_s[0], slave_select_input_n_i};
      next_st.nss_prev = st.nss_s[1];
      next_st.done_s = {st.done_s[1:0], lk.done_tgl};
      next_st.slave_selected_flag = !st.nss_s[1];
      // Set wins over a clear in the same cycle
      next_st.transfer_done_flag = set_done
         || (st.transfer_done_flag
         && !(ctrl_wr && !sfr_wdata_i[`SPS_DONE_BIT]));
      next_st.write_collision_flag = set_write_collision_flag
         || (st.write_collision_flag
         && !(ctrl_wr && !sfr_wdata_i[`SPS_WRITE_COLLISION_FLAG_BIT]));
      next_st.mode_fault_flag = fault
         || (st.mode_fault_flag
         && !(ctrl_wr && !sfr_wdata_i[`SPS_MODE_FAULT_FLAG_BIT]));
      next_st.receive_overrun_flag = set_ovr
         || (st.receive_overrun_flag
         && !(ctrl_wr && !sfr_wdata_i[`SPS_OVR_BIT]));
      if (done_evt) begin
         next_st.transmit_busy_flag = 1'b0;
      end
      if (ctrl_wr) begin
         next_st.master_enable = sfr_wdata_i[`SPS_MST_BIT];
         next_st.interface_enable = sfr_wdata_i[`SPS_EN_BIT];
      end
      if (fault) begin
         next_st.master_enable = 1'b0;
         next_st.interface_enable = 1'b0;
      end
      if (cfg_wr) begin
         next_st.clk_cfg = sfr_wdata_i[7:6];
         next_st.frame_length_select = sfr_wdata_i[2:0];
      end
      // Colliding writes never reach the shifter
      if (data_wr && !in_prog) begin
         next_st.tx_word = sfr_wdata_i;
         next_st.flen_tx = st.frame_length_select;
         if (st.interface_enable && st.master_enable && !fault) begin
            next_st.start_tgl = ~st.start_tgl;
            next_st.transmit_busy_flag = 1'b1;
         end else begin
            next_st.load_tgl = ~st.load_tgl;
         end
      end
      if (sfr_rd_i) begin
         case (sfr_addr_i)
            `SPS_CTRL_ADDR: begin
               next_st.rdata = {st.transfer_done_flag,
                  st.write_collision_flag, st.mode_fault_flag,
                  st.receive_overrun_flag, st.transmit_busy_flag,
                  st.slave_selected_flag, st.master_enable,
                  st.interface_enable};
            end
            `SPS_CFG_ADDR: begin
               next_st.rdata = {st.clk_cfg, 3'h0,
                  st.frame_length_select};
            end
            `SPS_DATA_ADDR: begin
               next_st.rdata = buf_valid ? buf_data : 8'h00;
            end
            default: begin
               next_st.rdata = 8'h00;
            end
         endcase
      end
      next_st.irq = next_st.transfer_done_flag
         || next_st.write_collision_flag
         || next_st.mode_fault_flag
         || next_st.receive_overrun_flag;
      next_st.drive_oe = next_st.interface_enable
         && next_st.master_enable;
      next_st.miso_oe = next_st.interface_enable
         && !next_st.master_enable && !st.nss_s[1];
   end

   // ===========================================
   // State register
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         st <= '0;
         st.nss_s <= 2'b11;
         st.nss_prev <= 1'b1;
         st.frame_length_select <= `SPS_FLEN_RESET;
         st.flen_tx <= `SPS_FLEN_RESET;
      end else begin
         st <= next_st;
      end
   end

   assign sfr_rdata_o = st.rdata;
   assign irq_o = st.irq;
   assign sck_oe_o = st.drive_oe;
   assign mosi_oe_o = st.drive_oe;
   assign miso_oe_o = st.miso_oe;

   // ===========================================
   // Checks
   done_sticky_a: assert property (@(posedge clk_i)
      disable iff (!resetn_i)
      st.transfer_done_flag
         && !(ctrl_wr && !sfr_wdata_i[`SPS_DONE_BIT])
      |=> st.transfer_done_flag)
      else $error("done flag dropped without clear");

   done_irq_a: assert property (@(posedge clk_i)
      disable iff (!resetn_i)
      set_done |=> st.transfer_done_flag && irq_o)
      else $error("done did not raise request");

   write_collision_flag_set_a: assert property (@(posedge clk_i)
      disable iff (!resetn_i)
      data_wr && in_prog |=> st.write_collision_flag)
      else $error("collision flag not set");

   mode_fault_flag_set_a: assert property (@(posedge clk_i)
      disable iff (!resetn_i)
      st.interface_enable && st.master_enable && !st.nss_s[1]
      |=> st.mode_fault_flag)
      else $error("mode fault not flagged");

   err_irq_a: assert property (@(posedge clk_i)
      disable iff (!resetn_i)
      $rose(st.mode_fault_flag) || $rose(st.write_collision_flag)
         || $rose(st.receive_overrun_flag)
      |-> irq_o)
      else $error("error flag without request");

   sticky_err_a: assert property (@(posedge clk_i)
      disable iff (!resetn_i)
      !ctrl_wr
      |=> !$fell(st.mode_fault_flag) && !$fell(st.receive_overrun_flag))
      else $error("fault or overrun cleared by hardware");

   ovr_set_a: assert property (@(posedge clk_i)
      disable iff (!resetn_i)
      byte_evt && !buf_ready |=> st.receive_overrun_flag)
      else $error("overrun not flagged");

   busy_hold_a: assert property (@(posedge clk_i)
      disable iff (!resetn_i)
      st.transmit_busy_flag && !done_evt |=> st.transmit_busy_flag)
      else $error("busy dropped mid transfer");

   busy_start_a: assert property (@(posedge clk_i)
      disable iff (!resetn_i)
      data_wr && !in_prog && st.interface_enable && st.master_enable
         && !fault
      |=> st.transmit_busy_flag ##0 $changed(st.start_tgl))
      else $error("master write did not start");

   busy_end_a: assert property (@(posedge clk_i)
      disable iff (!resetn_i)
      st.transmit_busy_flag && done_evt
      |=> !st.transmit_busy_flag && st.transfer_done_flag)
      else $error("busy not cleared at end");

   write_collision_flag_drop_a: assert property (@(posedge clk_i)
      disable iff (!resetn_i)
      data_wr && in_prog
      |=> $stable(st.tx_word) && $stable(st.start_tgl)
         && $stable(st.load_tgl))
      else $error("colliding write disturbed transfer");

   ovr_keep_a: assert property (@(posedge clk_i)
      disable iff (!resetn_i)
      byte_evt && !buf_ready && !data_rd |=> $stable(buf_data))
      else $error("overrun replaced held byte");

   fault_off_a: assert property (@(posedge clk_i)
      disable iff (!resetn_i)
      fault |=> !st.master_enable && !st.interface_enable
         ##1 !sck_oe_o)
      else $error("fault left interface on");

   sel_track_a: assert property (@(posedge clk_i)
      disable iff (!resetn_i)
      !st.nss_s[1] ##1 !st.nss_s[1] |-> st.slave_selected_flag)
      else $error("selected flag wrong");
endmodule
